//--- core/add_and_bit_op_datapath.sv
/*
 Execution datapath for add, AND, bit clear/set and bit test with skip.
 Assumes the decoder presents one operation per cycle with opValid, and the file
 register memory answers fileRdAddr combinationally on fileRdData in the same cycle.
*/
// What this block does
// - Add literal sums the accumulator with an 8-bit literal into the accumulator and updates carry, nibble carry and zero.
// - Add register sums the accumulator with the addressed file register into the accumulator or the register by the destination bit and updates all three flags.
// - AND literal ANDs the accumulator with the literal into the accumulator and updates only zero.
// - AND register ANDs the accumulator with the file register into the chosen destination and updates only zero.
// - Bit clear forces the selected bit of the register to zero and leaves other bits and flags alone.
// - Bit set forces the selected bit of the register to one and leaves other bits and flags alone.
// - Test skip if clear discards the next instruction as a no-operation when the bit is zero.
// - Test skip if set discards the next instruction as a no-operation when the bit is one.
// - Bit tests change no flag and do not write the tested register.
// - A read of the port register takes the pin levels instead of the output latch.
`timescale 1ns/1ps
`include "add_and_bit_op_regs.svh"

module add_and_bit_op_datapath (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic opValid,
  input wire add_and_bit_op_pkg::instr_t instr,
  output logic [`ADDR_W-1:0] fileRdAddr,
  input wire logic [`DATA_W-1:0] fileRdData,
  input wire logic [`DATA_W-1:0] pinLevels,
  output logic squash,
  output logic skipTaken,
  output logic fileWrEn,
  output logic [`ADDR_W-1:0] fileWrAddr,
  output logic [`DATA_W-1:0] fileWrData,
  output logic [`DATA_W-1:0] acc,
  output add_and_bit_op_pkg::flags_t flags
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [`DATA_W-1:0] bitMask(input logic [`BIT_W-1:0] idx);
    bitMask = 8'h01 << idx;
  endfunction

  function automatic logic isPort(input logic [`ADDR_W-1:0] addr);
    isPort = (addr == `PORT_ADDR);
  endfunction

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [`DATA_W-1:0] pinMeta;
  logic [`DATA_W-1:0] pinSync;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end else begin
      pinMeta <= pinLevels;
      pinSync <= pinMeta;
    end
  end

  // ****************************************
  // Operand fetch
  // ****************************************
  logic [`DATA_W-1:0] readVal;
  logic [`DATA_W-1:0] aluB;
  logic [`DATA_W-1:0] aluResult;
  add_and_bit_op_pkg::flags_t aluFlags;
  add_and_bit_op_pkg::state_t state;
  add_and_bit_op_pkg::state_t next_state;
  logic taken;
  logic litOp;
  logic testBit;

  assign fileRdAddr = instr.addr;
  // Pins rather than latch, so an input pin driven low reads back low
  assign readVal = isPort(instr.addr) ? pinSync : fileRdData;
  assign litOp = (instr.op == add_and_bit_op_pkg::ADD_LITERAL_OP) ||
                 (instr.op == add_and_bit_op_pkg::AND_LITERAL_OP);
  assign aluB = litOp ? instr.literal : readVal;
  assign taken = opValid && (state == add_and_bit_op_pkg::EXEC);
  assign squash = opValid && (state == add_and_bit_op_pkg::SKIP);
  assign testBit = |(readVal & bitMask(instr.bitIdx));

  add_and_alu u_alu (
    .opA(acc),
    .opB(aluB),
    .selAnd((instr.op == add_and_bit_op_pkg::AND_LITERAL_OP) ||
            (instr.op == add_and_bit_op_pkg::AND_REGISTER_OP)),
    .result(aluResult),
    .flags(aluFlags)
  );

  // ****************************************
  // Execute
  // ****************************************
  logic [`DATA_W-1:0] next_acc;
  add_and_bit_op_pkg::flags_t next_flags;
  logic next_fileWrEn;
  logic [`ADDR_W-1:0] next_fileWrAddr;
  logic [`DATA_W-1:0] next_fileWrData;
  logic next_skipTaken;

  always_comb begin
    next_acc = acc;
    next_flags = flags;
    next_fileWrEn = 1'b0;
    next_fileWrAddr = fileWrAddr;
    next_fileWrData = fileWrData;
    next_skipTaken = 1'b0;
    next_state = state;
    if (squash) begin
      // Discarded instruction runs as a no-operation
      next_state = add_and_bit_op_pkg::EXEC;
    end else if (taken) begin
      case (instr.op)
        add_and_bit_op_pkg::ADD_LITERAL_OP: begin
          next_acc = aluResult;
          next_flags = aluFlags;
        end
        add_and_bit_op_pkg::ADD_REGISTER_OP: begin
          next_flags = aluFlags;
          if (instr.dest) begin
            next_fileWrEn = 1'b1;
            next_fileWrAddr = instr.addr;
            next_fileWrData = aluResult;
          end else begin
            next_acc = aluResult;
          end
        end
        add_and_bit_op_pkg::AND_LITERAL_OP: begin
          next_acc = aluResult;
          next_flags.zero = aluFlags.zero;
        end
        add_and_bit_op_pkg::AND_REGISTER_OP: begin
          next_flags.zero = aluFlags.zero;
          if (instr.dest) begin
            next_fileWrEn = 1'b1;
            next_fileWrAddr = instr.addr;
            next_fileWrData = aluResult;
          end else begin
            next_acc = aluResult;
          end
        end
        add_and_bit_op_pkg::BIT_CLEAR_OP: begin
          next_fileWrEn = 1'b1;
          next_fileWrAddr = instr.addr;
          next_fileWrData = readVal & ~bitMask(instr.bitIdx);
        end
        add_and_bit_op_pkg::BIT_SET_OP: begin
          next_fileWrEn = 1'b1;
          next_fileWrAddr = instr.addr;
          next_fileWrData = readVal | bitMask(instr.bitIdx);
        end
        add_and_bit_op_pkg::TEST_SKIP_IF_CLEAR_OP: begin
          if (!testBit) begin
            next_skipTaken = 1'b1;
            next_state = add_and_bit_op_pkg::SKIP;
          end
        end
        add_and_bit_op_pkg::TEST_SKIP_IF_SET_OP: begin
          if (testBit) begin
            next_skipTaken = 1'b1;
            next_state = add_and_bit_op_pkg::SKIP;
          end
        end
        default: begin
          next_state = add_and_bit_op_pkg::EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      acc <= `ACC_RESET;
      flags <= {`FLAG_RESET, `FLAG_RESET, `FLAG_RESET};
      fileWrEn <= 1'b0;
      fileWrAddr <= 7'h00;
      fileWrData <= 8'h00;
      skipTaken <= 1'b0;
      state <= add_and_bit_op_pkg::EXEC;
    end else begin
      acc <= next_acc;
      flags <= next_flags;
      fileWrEn <= next_fileWrEn;
      fileWrAddr <= next_fileWrAddr;
      fileWrData <= next_fileWrData;
      skipTaken <= next_skipTaken;
      state <= next_state;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic isTest;
  assign isTest = (instr.op == add_and_bit_op_pkg::TEST_SKIP_IF_CLEAR_OP) ||
                  (instr.op == add_and_bit_op_pkg::TEST_SKIP_IF_SET_OP);

  property p_addLit;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::ADD_LITERAL_OP |=>
        acc == 8'($past(acc) + $past(instr.literal)) && !fileWrEn;
  endproperty
  a_addLit: assert property (p_addLit) else $error("add literal result wrong");

  property p_addReg;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::ADD_REGISTER_OP && instr.dest |=>
        fileWrEn && fileWrData == 8'($past(acc) + $past(readVal)) && $stable(acc);
  endproperty
  a_addReg: assert property (p_addReg) else $error("add register writeback wrong");

  property p_andLit;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::AND_LITERAL_OP |=>
        acc == ($past(acc) & $past(instr.literal)) && $stable(flags.carry) &&
        $stable(flags.nibbleCarryFlag) && flags.zero == (acc == 8'h00);
  endproperty
  a_andLit: assert property (p_andLit) else $error("and literal wrong");

  property p_andReg;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::AND_REGISTER_OP && !instr.dest |=>
        !fileWrEn && acc == ($past(acc) & $past(readVal)) && $stable(flags.carry);
  endproperty
  a_andReg: assert property (p_andReg) else $error("and register wrong");

  property p_bitClear;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::BIT_CLEAR_OP |=>
        fileWrEn && fileWrData == ($past(readVal) & ~bitMask($past(instr.bitIdx))) &&
        $stable(flags);
  endproperty
  a_bitClear: assert property (p_bitClear) else $error("bit clear wrong");

  property p_bitSet;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::BIT_SET_OP |=>
        fileWrEn && fileWrData == ($past(readVal) | bitMask($past(instr.bitIdx))) &&
        $stable(flags) && $stable(acc);
  endproperty
  a_bitSet: assert property (p_bitSet) else $error("bit set wrong");

  property p_skipClear;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::TEST_SKIP_IF_CLEAR_OP |=>
        skipTaken == !$past(testBit) && (state == add_and_bit_op_pkg::SKIP) == skipTaken;
  endproperty
  a_skipClear: assert property (p_skipClear) else $error("skip if clear wrong");

  property p_skipSet;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::TEST_SKIP_IF_SET_OP |=>
        skipTaken == $past(testBit) && (state == add_and_bit_op_pkg::SKIP) == skipTaken;
  endproperty
  a_skipSet: assert property (p_skipSet) else $error("skip if set wrong");

  property p_squashNop;
    @(posedge clk_sys) disable iff (!rst_b)
      squash |=> !fileWrEn && $stable(acc) && $stable(flags) && !skipTaken;
  endproperty
  a_squashNop: assert property (p_squashNop) else $error("discarded op had effect");

  property p_testQuiet;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && isTest |=> !fileWrEn && $stable(flags) && $stable(acc);
  endproperty
  a_testQuiet: assert property (p_testQuiet) else $error("bit test changed state");

  property p_portRead;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && isPort(instr.addr) && instr.op == add_and_bit_op_pkg::BIT_CLEAR_OP |=>
        (fileWrData | bitMask($past(instr.bitIdx))) ==
          ($past(pinSync) | bitMask($past(instr.bitIdx)));
  endproperty
  a_portRead: assert property (p_portRead) else $error("port read not from pins");

  property p_addFlags;
    @(posedge clk_sys) disable iff (!rst_b)
      taken && instr.op == add_and_bit_op_pkg::ADD_LITERAL_OP |=>
        flags.zero == (acc == 8'h00) &&
        flags.carry == (({1'b0, $past(acc)} + {1'b0, $past(instr.literal)}) > 9'h0ff) &&
        flags.nibbleCarryFlag ==
          (({1'b0, $past(acc[3:0])} + {1'b0, $past(instr.literal[3:0])}) > 5'h0f);
  endproperty
  a_addFlags: assert property (p_addFlags) else $error("add flags wrong");

endmodule

//--- include/add_and_bit_op_regs.svh
/*
 Holds the offsets, reset values and field positions of the add and bit-op datapath.
 Assumes that it is included by bare name; the guard makes repeated inclusion in one compile unit harmless.
*/
`ifndef ADD_AND_BIT_OP_REGS_SVH
`define ADD_AND_BIT_OP_REGS_SVH

// ****************************************
// Widths and limits
// ****************************************
`define DATA_W 8
`define ADDR_W 7
`define BIT_W 3
`define NIBBLE_MSB 3
// ****************************************
// Reset values
// ****************************************
`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0
// ****************************************
// Address of the port register read from the pins
// ****************************************
`define PORT_ADDR 7'h05

`endif

//--- include/add_and_bit_op_pkg.sv
/*
 Types shared by the datapath: the operation code, the decoded operation and the flags.
 Assumes the constants header is on the include path.
*/
`include "add_and_bit_op_regs.svh"

package add_and_bit_op_pkg;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [3:0] {
    NO_OP = 4'h0,
    ADD_LITERAL_OP = 4'h1,
    ADD_REGISTER_OP = 4'h2,
    AND_LITERAL_OP = 4'h3,
    AND_REGISTER_OP = 4'h4,
    BIT_CLEAR_OP = 4'h5,
    BIT_SET_OP = 4'h6,
    TEST_SKIP_IF_CLEAR_OP = 4'h7,
    TEST_SKIP_IF_SET_OP = 4'h8
  } op_t;

  typedef struct packed {
    op_t op;
    logic [`DATA_W-1:0] literal;
    logic [`ADDR_W-1:0] addr;
    logic [`BIT_W-1:0] bitIdx;
    logic dest;
  } instr_t;

  typedef struct packed {
    logic carry;
    logic nibbleCarryFlag;
    logic zero;
  } flags_t;

  // Gray along EXEC -> SKIP -> EXEC
  typedef enum logic [1:0] {
    EXEC = 2'b00,
    SKIP = 2'b01
  } state_t;

endpackage

//--- core/add_and_alu.sv
/*
 Adder and AND unit with flag generation.
 Assumes operands are stable within the cycle; purely combinational.
*/
`timescale 1ns/1ps
`include "add_and_bit_op_regs.svh"

module add_and_alu (
  input wire logic [`DATA_W-1:0] opA,
  input wire logic [`DATA_W-1:0] opB,
  input wire logic selAnd,
  output logic [`DATA_W-1:0] result,
  output add_and_bit_op_pkg::flags_t flags
);

  logic [`DATA_W:0] sum;
  logic [`NIBBLE_MSB+1:0] lowSum;

  always_comb begin
    sum = {1'b0, opA} + {1'b0, opB};
    lowSum = {1'b0, opA[`NIBBLE_MSB:0]} + {1'b0, opB[`NIBBLE_MSB:0]};
    result = selAnd ? (opA & opB) : sum[`DATA_W-1:0];
    flags.carry = sum[`DATA_W];
    flags.nibbleCarryFlag = lowSum[`NIBBLE_MSB+1];
    flags.zero = (result == 8'h00);
  end

endmodule

//--- testbench/file_reg_model.sv
/*
 Behavioural file register memory that faces the datapath.
 Assumes the bench preloads cells by hierarchical write at the falling edge.
*/
`timescale 1ns/1ps
module file_reg_model (
  input wire logic clk_sys,
  input wire logic [6:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [7:0] wrData
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem [0:127];
  // Cleared at start so that no unknown leaks into unused operand reads
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Combinational read: the datapath samples it in the same cycle
  assign rdData = mem[rdAddr];
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule

//--- testbench/testbench.sv
/*
 Self-checking bench for the add and bit-op datapath.
 Assumes the file register model and the design package are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic opValid = 1'b0;
  add_and_bit_op_pkg::instr_t instr = '0;
  logic [7:0] pinLevels = 8'ha5;
  logic [6:0] fileRdAddr;
  logic [7:0] fileRdData;
  logic squash;
  logic skipTaken;
  logic fileWrEn;
  logic [6:0] fileWrAddr;
  logic [7:0] fileWrData;
  logic [7:0] acc;
  add_and_bit_op_pkg::flags_t flags;
  int err_count = 0;
  int checked = 0;
  logic sq;
  logic [7:0] ea;
  logic [7:0] ef;
  always #2.5 clk_sys = ~clk_sys;
  add_and_bit_op_datapath u_add_and_bit_op_datapath (
    .clk_sys(clk_sys), .rst_b(rst_b), .opValid(opValid), .instr(instr),
    .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .pinLevels(pinLevels),
    .squash(squash), .skipTaken(skipTaken), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .acc(acc), .flags(flags));
  file_reg_model u_file_reg_model (
    .clk_sys(clk_sys), .rdAddr(fileRdAddr), .rdData(fileRdData),
    .wrEn(fileWrEn), .wrAddr(fileWrAddr), .wrData(fileWrData));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] fl();
    return {5'h00, flags};
  endfunction
  // Presents one instruction and returns at the next falling edge; valid stays up,
  // so the next call follows back to back without a second drive in one time step
  task automatic run(input add_and_bit_op_pkg::op_t op, input logic [7:0] k,
                     input logic [6:0] a, input logic [2:0] b, input logic d);
    opValid = 1'b1;
    instr = '{op, k, a, b, d};
    #1 sq = squash;
    @(negedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_add();
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'h8f, 7'h00, 3'd0, 1'b0);
    chk(acc, 8'h8f);
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'h71, 7'h00, 3'd0, 1'b0);
    chk(acc, 8'h00);
    chk(fl(), 8'h07);
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'h09, 7'h00, 3'd0, 1'b0);
    u_file_reg_model.mem[10] = 8'h08;
    run(add_and_bit_op_pkg::ADD_REGISTER_OP, 8'h00, 7'h0a, 3'd0, 1'b1);
    chk({7'h00, fileWrEn}, 8'h01);
    chk({1'b0, fileWrAddr}, 8'h0a);
    chk(fileWrData, 8'h11);
    chk(acc, 8'h09);
    chk(fl(), 8'h02);
    u_file_reg_model.mem[127] = 8'hf7;
    run(add_and_bit_op_pkg::ADD_REGISTER_OP, 8'h00, 7'h7f, 3'd0, 1'b0);
    chk({7'h00, fileWrEn}, 8'h00);
    chk(acc, 8'h00);
    chk(fl(), 8'h07);
  endtask
  // Carry set first so that an AND can be seen to leave it alone
  task automatic t_and();
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'hf0, 7'h00, 3'd0, 1'b0);
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'h18, 7'h00, 3'd0, 1'b0);
    chk(fl(), 8'h04);
    run(add_and_bit_op_pkg::AND_LITERAL_OP, 8'h07, 7'h00, 3'd0, 1'b0);
    chk(acc, 8'h00);
    chk(fl(), 8'h05);
    run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'hff, 7'h00, 3'd0, 1'b0);
    u_file_reg_model.mem[20] = 8'h5a;
    u_file_reg_model.mem[21] = 8'ha5;
    run(add_and_bit_op_pkg::AND_REGISTER_OP, 8'h00, 7'h14, 3'd0, 1'b1);
    chk(fileWrData, 8'h5a);
    chk(acc, 8'hff);
    run(add_and_bit_op_pkg::AND_REGISTER_OP, 8'h00, 7'h14, 3'd0, 1'b0);
    chk(acc, 8'h5a);
    run(add_and_bit_op_pkg::AND_REGISTER_OP, 8'h00, 7'h15, 3'd0, 1'b0);
    chk(acc, 8'h00);
    chk(fl(), 8'h01);
  endtask
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      u_file_reg_model.mem[30] = 8'hff;
      run(add_and_bit_op_pkg::BIT_CLEAR_OP, 8'h00, 7'h1e, b[2:0], 1'b0);
      chk(fileWrData, 8'hff & ~(8'h01 << b));
      chk(fl(), 8'h01);
      u_file_reg_model.mem[31] = 8'h00;
      run(add_and_bit_op_pkg::BIT_SET_OP, 8'h00, 7'h1f, b[2:0], 1'b0);
      chk(fileWrData, 8'h01 << b);
      chk(fl(), 8'h01);
    end
  endtask
  // Each test is followed at once by an add that must vanish on a skip
  task automatic t_skip();
    logic skp;
    ea = 8'h00;
    ef = 8'h01;
    u_file_reg_model.mem[40] = 8'h0f;
    for (int i = 0; i < 4; i++) begin
      skp = (i < 2) ? (i == 0) : (i == 2);
      run((i < 2) ? add_and_bit_op_pkg::TEST_SKIP_IF_CLEAR_OP :
          add_and_bit_op_pkg::TEST_SKIP_IF_SET_OP, 8'h00, 7'h28,
          (i[0] ^ (i > 1)) ? 3'd0 : 3'd4, 1'b0);
      chk({7'h00, skipTaken}, {7'h00, skp});
      chk({7'h00, fileWrEn}, 8'h00);
      chk(fl(), ef);
      run(add_and_bit_op_pkg::ADD_LITERAL_OP, 8'h01, 7'h00, 3'd0, 1'b0);
      chk({7'h00, sq}, {7'h00, skp});
      if (!skp) begin
        ea = ea + 8'h01;
        ef = 8'h00;
      end
      chk(acc, ea);
    end
  endtask
  // Port cell holds 0 in the latch while the pins show another value
  task automatic t_port();
    u_file_reg_model.mem[5] = 8'h00;
    run(add_and_bit_op_pkg::BIT_SET_OP, 8'h00, 7'h05, 3'd1, 1'b0);
    chk(fileWrData, 8'ha7);
    // New pin levels need two cycles through the synchroniser before the read
    pinLevels = 8'h3c;
    run(add_and_bit_op_pkg::NO_OP, 8'h00, 7'h00, 3'd0, 1'b0);
    run(add_and_bit_op_pkg::NO_OP, 8'h00, 7'h00, 3'd0, 1'b0);
    run(add_and_bit_op_pkg::BIT_CLEAR_OP, 8'h00, 7'h05, 3'd2, 1'b0);
    chk(fileWrData, 8'h38);
  endtask
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    chk(acc, 8'h00);
    chk(fl(), 8'h00);
    t_add();
    t_and();
    t_bits();
    t_skip();
    t_port();
    give_verdict();
  end
  // About 44 cycles are needed; this allows a wide margin
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule
